// File: yag_cfg.svh
// Constants for the T1 transmit yellow alarm generator.
// Assumes inclusion by bare name from the package and the design module.
`ifndef YAG_CFG_SVH
`define YAG_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define YAG_ADDR_W          8
`define YAG_ADDR_ALARM_GEN  8'h08
`define YAG_ADDR_STATUS     8'h09
`define YAG_ADDR_PAT_COUNT  8'h0a
`define YAG_ALARM_GEN_RST   8'h00

// ----------------------------------------------------------------------------
// Alarm generation fields
// ----------------------------------------------------------------------------
`define YAG_RULE_BIT        7
`define YAG_ENABLE_BIT      6
`define YAG_SEL_HI          5
`define YAG_SEL_LO          4
`define YAG_STORED_MASK     8'hf0

// ----------------------------------------------------------------------------
// Alarm select codes and framing constants
// ----------------------------------------------------------------------------
`define YAG_SEL_NONE        2'h0
`define YAG_SEL_ONE         2'h1
`define YAG_SEL_TWO         2'h2
`define YAG_SEL_THREE       2'h3
`define YAG_FS_FRAME        4'hc
`define YAG_PATTERN_LIMIT   255
`define YAG_PAT_BITS        16
`define YAG_PAT_LAST        4'hf
`define YAG_PAT_ONES_END    4'h8

`endif

// File: yag_pkg.sv
// Types shared by the yellow alarm generator.
// Assumes yag_cfg.svh is on the include path.
`include "yag_cfg.svh"

package yag_pkg;

	// Transmit framing mode supplied by the framer
	typedef enum logic [1:0] {
		YAG_MODE_SF,
		YAG_MODE_N,
		YAG_MODE_DS1DC,
		YAG_MODE_ESF
	} yag_mode_e;

	typedef logic [1:0] yag_sel_t;

endpackage : yag_pkg

// File: yag_top.sv
// Transmit yellow alarm (remote alarm indication) generator, one T1 channel.
// Assumes the framer supplies the framing mode, the frame number and a one
// cycle pulse per ESF data link bit slot; all inputs are synchronous.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
`include "yag_cfg.svh"

module yag_top #(
	parameter int unsigned PATTERN_LIMIT = `YAG_PATTERN_LIMIT
) (
	// Clock and reset
	input  wire logic                     clock_i,
	input  wire logic                     nrst_i,
	// Register port
	input  wire logic [`YAG_ADDR_W-1:0]   addr_i,
	input  wire logic [7:0]               wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	output logic      [7:0]               rdata_o,
	// Framer timing
	input  wire yag_pkg::yag_mode_e       frame_mode_i,
	input  wire logic [3:0]               frame_num_i,
	input  wire logic                     dl_slot_i,
	// Alarm insertion controls
	output logic                          ds0_bit2_zero_o,
	output logic                          ybit_zero_o,
	output logic                          fs_bit_one_o,
	output logic                          dl_override_o,
	output logic                          dl_data_o,
	output logic                          rule_enforced_o
);
	import yag_pkg::*;

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	logic [7:0] alarm_generation_reg;
	logic       sel_low_prev_reg;
	logic       running_reg;
	logic       running_next;
	logic       dl_active_reg;
	logic       dl_active_next;
	logic [3:0] bit_idx_reg;
	logic [3:0] bit_idx_next;
	logic [7:0] pat_cnt_reg;
	logic [7:0] pat_cnt_next;
	logic       dl_data_reg;
	logic       ones_reg;
	logic       ds0_zero_reg;
	logic       ybit_zero_reg;
	logic       fs_one_reg;
	logic [7:0] rdata_reg;

	localparam logic [7:0] LIMIT_M1 = 8'(PATTERN_LIMIT - 1);

	function automatic logic sel_is(input yag_sel_t s, input yag_sel_t code);
		return s == code;
	endfunction : sel_is

	// ------------------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------------------
	wire        rule_on    = alarm_generation_reg[`YAG_RULE_BIT];
	wire        free_rule  = !rule_on;
	wire yag_sel_t sel     = alarm_generation_reg[`YAG_SEL_HI:`YAG_SEL_LO];
	wire        sel_low    = sel[0];
	wire        sel_high   = sel[1];
	wire        mode_esf   = frame_mode_i == YAG_MODE_ESF;
	wire        mode_sf    = frame_mode_i == YAG_MODE_SF;
	wire        mode_sfn   = mode_sf || frame_mode_i == YAG_MODE_N;
	wire        mode_dc    = frame_mode_i == YAG_MODE_DS1DC;
	wire        sel_any    = !sel_is(sel, `YAG_SEL_NONE);

	// Bit 2 zero for 01 and 11 in SF or N
	wire        ds0_want   = free_rule && mode_sfn
	                         && (sel_is(sel, `YAG_SEL_ONE)
	                         || sel_is(sel, `YAG_SEL_THREE));
	// Y bit zero for any non-zero select in data channel mode
	wire        ybit_want  = free_rule && mode_dc && sel_any;
	// Fs bit one in frame 12 for 10 in SF
	wire        fs_want    = free_rule && mode_sf && sel_is(sel, `YAG_SEL_TWO)
	                         && frame_num_i == `YAG_FS_FRAME;

	// ESF duration control
	wire        esf_low    = free_rule && mode_esf && sel_low;
	wire        esf_high   = free_rule && mode_esf && sel_is(sel, `YAG_SEL_TWO);
	wire        esf_mode   = free_rule && mode_esf;
	wire        low_rise   = sel_low && !sel_low_prev_reg;
	wire        pat_end    = dl_active_reg && dl_slot_i && bit_idx_reg == `YAG_PAT_LAST;
	wire        cnt_done   = pat_end && running_reg && pat_cnt_reg == LIMIT_M1;
	// A started pulse outlives its select bit; a held select keeps the link busy
	wire        esf_want   = esf_mode && (running_reg || sel_any);
	// Another pattern follows while the count runs or any select is held
	wire        pat_keep   = (running_reg && !cnt_done) || sel_any;
	wire        all_ones   = sel_is(sel, `YAG_SEL_THREE);
	// Pattern kind of the last non-zero select, so a cleared pulse keeps it
	wire        ones_now   = sel_any ? all_ones : ones_reg;

	// ------------------------------------------------------------------------
	// ESF pulse counter
	// ------------------------------------------------------------------------
	always_comb begin
		running_next = running_reg;
		// Only leaving ESF, an enforced rule or the limit ends a started pulse;
		// clearing the select bit alone does not
		if (!esf_mode) begin
			running_next = 1'b0;
		end else if (esf_low && low_rise) begin
			running_next = 1'b1;
		end else if (cnt_done) begin
			running_next = 1'b0;
		end
	end

	always_comb begin
		pat_cnt_next = pat_cnt_reg;
		// A new pulse restarts the count; the pattern in flight counts as first
		if (!esf_mode || (esf_low && low_rise)) begin
			pat_cnt_next = 8'h00;
		end else if (pat_end && running_reg && !cnt_done) begin
			pat_cnt_next = pat_cnt_reg + 8'h01;
		end
	end

	// ------------------------------------------------------------------------
	// ESF data link pattern
	// ------------------------------------------------------------------------
	// Leaving ESF or an enforced rule ends the alarm at once; otherwise it ends only on a pattern boundary
	always_comb begin
		dl_active_next = dl_active_reg;
		bit_idx_next   = bit_idx_reg;
		if (!esf_mode) begin
			dl_active_next = 1'b0;
			bit_idx_next   = 4'h0;
		end else if (!dl_active_reg) begin
			dl_active_next = esf_want;
			bit_idx_next   = 4'h0;
		end else if (dl_slot_i) begin
			bit_idx_next = bit_idx_reg + 4'h1;
			if (pat_end && !pat_keep) begin
				dl_active_next = 1'b0;
			end
		end
	end

	// Pattern bit for the next slot, ones first
	wire        pat_bit    = ones_now || bit_idx_next < `YAG_PAT_ONES_END;

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			alarm_generation_reg <= `YAG_ALARM_GEN_RST;
		end else if (wr_i && addr_i == `YAG_ADDR_ALARM_GEN) begin
			alarm_generation_reg <= wdata_i & `YAG_STORED_MASK;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sel_low_prev_reg <= 1'b0;
			running_reg      <= 1'b0;
			pat_cnt_reg      <= 8'h00;
			dl_active_reg    <= 1'b0;
			bit_idx_reg      <= 4'h0;
			dl_data_reg      <= 1'b0;
			ones_reg         <= 1'b0;
		end else begin
			sel_low_prev_reg <= sel_low;
			running_reg      <= running_next;
			pat_cnt_reg      <= pat_cnt_next;
			dl_active_reg    <= dl_active_next;
			bit_idx_reg      <= bit_idx_next;
			dl_data_reg      <= dl_active_next && pat_bit;
			ones_reg         <= ones_now;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ds0_zero_reg  <= 1'b0;
			ybit_zero_reg <= 1'b0;
			fs_one_reg    <= 1'b0;
		end else begin
			ds0_zero_reg  <= ds0_want;
			ybit_zero_reg <= ybit_want;
			fs_one_reg    <= fs_want;
		end
	end

	// ------------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------------
	// Read data stand one cycle after the strobe and read zero otherwise
	wire [7:0] status_word = {5'h00, dl_active_reg, running_reg, rule_on};
	wire [7:0] read_mux    = addr_i == `YAG_ADDR_ALARM_GEN ? alarm_generation_reg :
	                         addr_i == `YAG_ADDR_STATUS    ? status_word :
	                         addr_i == `YAG_ADDR_PAT_COUNT ? pat_cnt_reg : 8'h00;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_reg <= 8'h00;
		end else if (rd_i) begin
			rdata_reg <= read_mux;
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign rdata_o         = rdata_reg;
	assign ds0_bit2_zero_o = ds0_zero_reg;
	assign ybit_zero_o     = ybit_zero_reg;
	assign fs_bit_one_o    = fs_one_reg;
	assign dl_override_o   = dl_active_reg;
	assign dl_data_o       = dl_data_reg;
	assign rule_enforced_o = rule_on;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	// All checks sample on the rising edge and sleep during reset
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	sequence s_pulse_start;
		esf_low && low_rise;
	endsequence

	sequence s_running_on;
		running_reg && pat_cnt_reg == 8'h00;
	endsequence

	none_sel_quiet_a: assert property (
		$past(!sel_any) && !sel_any |-> !ds0_bit2_zero_o && !ybit_zero_o && !fs_bit_one_o)
		else $error("alarm output with select zero");

	ds0_force_a: assert property (
		free_rule && mode_sfn && sel_is(sel, `YAG_SEL_ONE) |=> ds0_bit2_zero_o)
		else $error("bit 2 not forced for select one");

	ybit_force_a: assert property (
		free_rule && mode_dc && sel_any |=> ybit_zero_o && !ds0_bit2_zero_o)
		else $error("y bit not forced in data channel mode");

	pulse_start_a: assert property (
		s_pulse_start |=> s_running_on)
		else $error("pulse did not start the pattern count");

	count_stop_a: assert property (
		esf_low && !low_rise && running_reg && pat_end && pat_cnt_reg == LIMIT_M1
		|=> !running_reg)
		else $error("pattern count did not stop at limit");

	count_step_a: assert property (
		esf_low && !low_rise && running_reg && pat_end && pat_cnt_reg < LIMIT_M1
		|=> pat_cnt_reg == $past(pat_cnt_reg) + 8'h01)
		else $error("pattern count did not advance");

	held_keeps_a: assert property (
		dl_active_reg && esf_low && sel_low && $past(esf_low && sel_low) |=> dl_active_reg)
		else $error("alarm stopped while low select held");

	restart_a: assert property (
		(s_pulse_start and running_reg) |=> pat_cnt_reg == 8'h00 ##0 running_reg)
		else $error("new pulse did not restart the count");

	fs_frame_a: assert property (
		fs_bit_one_o |-> $past(frame_num_i) == `YAG_FS_FRAME && $past(mode_sf))
		else $error("Fs forced outside frame 12");

	high_hold_a: assert property (
		esf_high ##1 (esf_high && dl_active_reg) |-> dl_active_reg [*1] ##1 dl_active_reg)
		else $error("high select alarm dropped");

	ones_pattern_a: assert property (
		dl_override_o && all_ones && $past(all_ones) && $past(dl_active_reg) |-> dl_data_o)
		else $error("sixteen ones pattern broken");

	enforced_idle_a: assert property (
		rule_on && $past(rule_on) |-> !ds0_bit2_zero_o && !ybit_zero_o && !fs_bit_one_o)
		else $error("unenforced alarm path active under enforced rule");

endmodule : yag_top

// File: yag_remote_rx.sv
// Remote terminal model: receives the ESF data link bits and tallies patterns.
// Assumes one dl_slot_i pulse per link bit and pattern alignment at override rise.
`timescale 1ns/1ns

module yag_remote_rx (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	// Link from the generator
	input  wire logic       clr_i,
	input  wire logic       dl_slot_i,
	input  wire logic       dl_override_i,
	input  wire logic       dl_data_i,
	// Received pattern tallies
	output logic      [7:0] ff00_cnt_o,
	output logic      [7:0] ffff_cnt_o,
	output logic      [7:0] bad_cnt_o
);
	// ------------------------------------------------------------------
	// Pattern capture
	// ------------------------------------------------------------------
	logic [15:0] shift_reg;
	logic [4:0]  bits_reg;
	wire  [15:0] word_next = {shift_reg[14:0], dl_data_i};
	wire         take      = dl_slot_i && dl_override_i;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{shift_reg, bits_reg, ff00_cnt_o, ffff_cnt_o, bad_cnt_o} <= '0;
		end else if (clr_i) begin
			{ff00_cnt_o, ffff_cnt_o, bad_cnt_o} <= '0;
		end else if (!dl_override_i && bits_reg != 5'h00) begin
			// A pattern cut short counts as faulty
			bad_cnt_o <= bad_cnt_o + 8'h01;
			bits_reg  <= 5'h00;
		end else if (take) begin
			shift_reg <= word_next;
			bits_reg  <= (bits_reg == 5'h0f) ? 5'h00 : bits_reg + 5'h01;
			if (bits_reg == 5'h0f) begin
				if (word_next == 16'hff00) ff00_cnt_o <= ff00_cnt_o + 8'h01;
				else if (word_next == 16'hffff) ffff_cnt_o <= ffff_cnt_o + 8'h01;
				else bad_cnt_o <= bad_cnt_o + 8'h01;
			end
		end
	end
endmodule : yag_remote_rx

// File: yag_top_tb_top.sv
// Self-checking bench for the yellow alarm generator.
// Assumes yag_pkg, yag_top and yag_remote_rx are compiled first.
`timescale 1ns/1ns

module yag_top_tb_top;
	import yag_pkg::*;
	localparam int LIM = 3;
	logic       clock_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic       dl_slot_i = 1'b0, clr = 1'b0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
	logic [3:0] frame_num_i = 4'hc;
	yag_mode_e  frame_mode_i = YAG_MODE_SF;
	logic [7:0] rdata_o, ff00_n, ffff_n, bad_n;
	logic       ds0_bit2_zero_o, ybit_zero_o, fs_bit_one_o;
	logic       dl_override_o, dl_data_o, rule_enforced_o;
	int         num_errors = 0, tests_run = 0, cycles = 0;

	yag_top #(.PATTERN_LIMIT(LIM)) dut (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .frame_mode_i, .frame_num_i, .dl_slot_i, .ds0_bit2_zero_o,
		.ybit_zero_o, .fs_bit_one_o, .dl_override_o, .dl_data_o, .rule_enforced_o);
	yag_remote_rx far_end (.clock_i, .nrst_i, .clr_i(clr), .dl_slot_i,
		.dl_override_i(dl_override_o), .dl_data_i(dl_data_o), .ff00_cnt_o(ff00_n),
		.ffff_cnt_o(ffff_n), .bad_cnt_o(bad_n));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic final_report();
		if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge clock_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		chk(name, exp, rdata_o);
	endtask : rd_chk

	task automatic slot();
		@(posedge clock_i);
		dl_slot_i <= 1'b1;
		@(posedge clock_i);
		dl_slot_i <= 1'b0;
		@(posedge clock_i);
	endtask : slot

	// Runs the link until the alarm ends, then judges the received tallies
	task automatic esf_finish(input int a, input int b);
		for (int n = 0; n < 600; n++) begin
			@(negedge clock_i);
			if (dl_override_o !== 1'b1) break;
			slot();
		end
		@(negedge clock_i);
		chk("ff00 patterns", a[7:0], ff00_n);
		chk("ffff patterns", b[7:0], ffff_n);
		chk("bad patterns", 8'h00, bad_n);
		@(posedge clock_i);
		clr <= 1'b1;
		@(posedge clock_i);
		clr <= 1'b0;
	endtask : esf_finish

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_regs();
		rd_chk(8'h08, 8'h00, "alarm_generation reset");
		wr(8'h08, 8'h4f);
		rd_chk(8'h08, 8'h40, "alarm_generation low bits");
		wr(8'h0b, 8'hff);
		rd_chk(8'h0b, 8'h00, "unmapped read");
		wr(8'h09, 8'hff);
		rd_chk(8'h09, 8'h00, "status read only");
		wr(8'h08, 8'h00);
	endtask : t_regs

	task automatic t_modes();
		logic [3:0] exp;
		for (int m = 0; m < 3; m++) for (int s = 0; s < 4; s++) begin
			@(posedge clock_i);
			frame_mode_i <= yag_mode_e'(m);
			wr(8'h08, {2'b00, s[1:0], 4'h0});
			repeat (2) @(posedge clock_i);
			@(negedge clock_i);
			exp = {m < 2 && s[0], m == 2 && s != 0, m == 0 && s == 2, 1'b0};
			chk("alarm outputs", {4'h0, exp}, {4'h0, ds0_bit2_zero_o, ybit_zero_o,
				fs_bit_one_o, dl_override_o});
		end
		@(posedge clock_i);
		frame_mode_i <= YAG_MODE_SF;
		frame_num_i  <= 4'h3;
		wr(8'h08, 8'h20);
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
		chk("Fs outside frame 12", 8'h00, {7'h00, fs_bit_one_o});
		@(posedge clock_i);
		frame_num_i  <= 4'hc;
	endtask : t_modes

	task automatic t_rule();
		@(posedge clock_i);
		frame_mode_i <= YAG_MODE_SF;
		wr(8'h08, 8'h90);
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
		chk("enforced outputs", 8'h02, {6'h00, rule_enforced_o, ds0_bit2_zero_o});
		rd_chk(8'h09, 8'h01, "status enforced");
		wr(8'h08, 8'h10);
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
		chk("unenforced outputs", 8'h01, {6'h00, rule_enforced_o, ds0_bit2_zero_o});
		wr(8'h08, 8'h00);
		@(posedge clock_i);
		frame_mode_i <= YAG_MODE_ESF;
	endtask : t_rule

	task automatic t_pulse(input logic [7:0] wv, input int a, input int b);
		wr(8'h08, wv);
		wr(8'h08, 8'h00);
		@(negedge clock_i);
		chk("override on pulse", 8'h01, {7'h00, dl_override_o});
		rd_chk(8'h09, 8'h06, "status pulse running");
		rd_chk(8'h0a, 8'h00, "pattern count start");
		esf_finish(a, b);
	endtask : t_pulse

	task automatic t_hold(input logic [7:0] wv, input int nslots, input int a);
		wr(8'h08, wv);
		repeat (nslots) slot();
		@(negedge clock_i);
		chk("override held", 8'h01, {7'h00, dl_override_o});
		wr(8'h08, 8'h00);
		esf_finish(a, 0);
	endtask : t_hold

	task automatic t_restart();
		wr(8'h08, 8'h10);
		wr(8'h08, 8'h00);
		repeat (24) slot();
		rd_chk(8'h0a, 8'h01, "pattern count one");
		wr(8'h08, 8'h10);
		wr(8'h08, 8'h00);
		esf_finish(LIM + 1, 0);
	endtask : t_restart

	// ------------------------------------------------------------------
	// Clock, reset, sequence and timeout
	// ------------------------------------------------------------------
	initial begin
		forever #25 clock_i = ~clock_i;
	end

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			final_report();
		end
	end

	initial begin
		repeat (10) @(posedge clock_i);
		nrst_i <= 1'b1;
		t_regs();
		t_modes();
		t_rule();
		t_pulse(8'h10, LIM, 0);
		t_pulse(8'h30, 0, LIM);
		t_hold(8'h10, 16 * (LIM + 2) + 8, LIM + 3);
		t_hold(8'h20, 16 * (LIM + 2) + 8, LIM + 3);
		t_restart();
		final_report();
	end
endmodule : yag_top_tb_top
